//--- hw/core_config_cfg.svh
`ifndef CORE_CONFIG_CFG_SVH
`define CORE_CONFIG_CFG_SVH

`define CFG_CREG_ADDR   12'h802
`define CFG_DBG_LOAD    8'hE2
`define CFG_DBG_STORE   8'hC2
`define CFG_RESET_VAL   32'h0000_0000
`define CFG_IMPL_MASK   32'hFA00_0000
`define CFG_BIT_ARD     31
`define CFG_BIT_IRD     30
`define CFG_BIT_IAE     29
`define CFG_BIT_IME     28
`define CFG_BIT_BWD     27
`define CFG_BIT_FSD     25
`define CFG_MASK_TOP    3'h7
`define CFG_MASK_RESET  3'h7
`define CFG_EDGE_LEVEL  3'h7
`define CFG_FLASH_CYC   2
`define CFG_FLASH_STEP  4

`endif

//--- hw/core_config_pkg.sv
package core_config_pkg;

	typedef struct packed
	{
		logic addr_err;
		logic bus_err;
		logic rte_fmt_err;
		logic fault_halt;
	} addr_fault_s;

	typedef struct packed
	{
		logic illegal_op;
		logic line_a;
		logic line_f;
		logic priv_viol;
	} instr_fault_s;

	typedef struct packed
	{
		logic addr_fault_reset_off;
		logic instr_fault_reset_off;
		logic vector_fetch_cycle_en;
		logic mask_raise_to_top;
		logic write_buffer_off;
		logic flash_spec_off;
	} cfg_bits_s;

	typedef enum logic [1:0] {IRQ_IDLE = 2'b01, IRQ_FETCH = 2'b10} irq_st_e;
	typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_BUSY = 2'b10} wr_st_e;
	typedef enum logic [2:0] {FL_IDLE = 3'b001, FL_DEMAND = 3'b010, FL_SPEC = 3'b100} fl_st_e;

endpackage : core_config_pkg

//--- hw/core_config_register.sv
// How it works
// [R1] address-class faults raise a reset event unless addr_fault_reset_off is set
// [R2] instruction-class faults raise a reset event unless instr_fault_reset_off is set
// [R3] vector_fetch_cycle_en runs a vector fetch cycle, else the signalled vector is used
// [R4] mask_raise_to_top sets mask to 7 on interrupt entry, else to serviced level
// [R5] buffered writes finish at once; unbuffered writes wait for memory acknowledge
// [R6] error returned for a buffered write is dropped, never reported
// [R7] flash_spec_off clear lets the flash path prefetch the next address
// [R8] a plain flash read occupies the flash array for two cycles
// [R9] register reached in supervisor mode at 0x802, or debug load E2 / store C2
// [R10] requests at or below the mask are blocked, except level 7 edges
// [R11] every configuration bit resets to zero
// [R12] reserved bits 26 and 24..0 are written zero and read back zero
`include "core_config_cfg.svh"

module core_config_register
	import core_config_pkg::*;
#(
	parameter int ADDR_W    = 24,
	parameter int FLASH_CYC = `CFG_FLASH_CYC
)(
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic              supervisor_in,
	input  wire logic              creg_req_in,
	input  wire logic              creg_write_in,
	input  wire logic [11:0]       creg_addr_in,
	input  wire logic [31:0]       creg_wdata_in,
	output logic                   creg_ack_out,
	output logic [31:0]            creg_rdata_out,
	input  wire logic              dbg_cmd_valid_in,
	input  wire logic [7:0]        dbg_cmd_in,
	input  wire logic [31:0]       dbg_wdata_in,
	output logic                   dbg_ack_out,
	output logic [31:0]            dbg_rdata_out,
	input  wire addr_fault_s       addr_fault_in,
	input  wire instr_fault_s      instr_fault_in,
	output logic                   reset_event_out,
	input  wire logic              irq_req_in,
	input  wire logic [2:0]        irq_level_in,
	input  wire logic [7:0]        irq_vector_in,
	output logic                   vector_fetch_cycle_out,
	input  wire logic              vector_fetch_ack_in,
	input  wire logic [7:0]        vector_fetch_data_in,
	output logic                   vector_valid_out,
	output logic [7:0]             vector_out,
	input  wire logic              mask_wr_in,
	input  wire logic [2:0]        mask_wdata_in,
	output logic [2:0]             irq_level_mask_out,
	input  wire logic              wr_req_in,
	input  wire logic [ADDR_W-1:0] wr_addr_in,
	input  wire logic [31:0]       wr_data_in,
	output logic                   wr_ready_out,
	output logic                   wr_done_out,
	output logic                   wr_err_out,
	output logic                   mem_wr_out,
	output logic [ADDR_W-1:0]      mem_addr_out,
	output logic [31:0]            mem_wdata_out,
	input  wire logic              mem_ack_in,
	input  wire logic              mem_err_in,
	input  wire logic              fl_req_in,
	input  wire logic [ADDR_W-1:0] fl_addr_in,
	output logic                   fl_ready_out,
	output logic                   fl_done_out,
	output logic [31:0]            fl_rdata_out,
	output logic                   flash_rd_out,
	output logic [ADDR_W-1:0]      flash_addr_out,
	input  wire logic [31:0]       flash_rdata_in
);

	localparam int                CNT_W    = $clog2(FLASH_CYC + 1);
	localparam logic [CNT_W-1:0]  CNT_LOAD = CNT_W'(FLASH_CYC - 1);
	localparam logic [ADDR_W-1:0] STEP     = ADDR_W'(`CFG_FLASH_STEP);

	logic [31:0] core_feature_config_ff;
	cfg_bits_s   cfg;
	assign cfg = '{core_feature_config_ff[`CFG_BIT_ARD], core_feature_config_ff[`CFG_BIT_IRD],
		core_feature_config_ff[`CFG_BIT_IAE], core_feature_config_ff[`CFG_BIT_IME],
		core_feature_config_ff[`CFG_BIT_BWD], core_feature_config_ff[`CFG_BIT_FSD]};

	// register access: supervisor control-register path and debug port
	wire         creg_hit  = creg_req_in && (creg_addr_in == `CFG_CREG_ADDR);
	wire         creg_ok   = creg_hit && supervisor_in;
	wire         creg_user = creg_hit && !supervisor_in;
	wire         dbg_store = dbg_cmd_valid_in && (dbg_cmd_in == `CFG_DBG_STORE);
	wire         dbg_load  = dbg_cmd_valid_in && (dbg_cmd_in == `CFG_DBG_LOAD);
	// debug store wins over a same-cycle supervisor write
	wire [31:0]  nxt_cfg   = dbg_store ? (dbg_wdata_in & `CFG_IMPL_MASK) :               // [R9] [R12]
		(creg_ok && creg_write_in) ? (creg_wdata_in & `CFG_IMPL_MASK) : core_feature_config_ff;

	// user-mode access is a privilege violation
	wire nxt_reset_event = (|addr_fault_in && !cfg.addr_fault_reset_off) ||               // [R1]
		((|instr_fault_in || creg_user) && !cfg.instr_fault_reset_off);                     // [R2]

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			core_feature_config_ff <= `CFG_RESET_VAL;                                       // [R11]
			creg_ack_out           <= 1'b0;
			creg_rdata_out         <= '0;
			dbg_ack_out            <= 1'b0;
			dbg_rdata_out          <= '0;
			reset_event_out        <= 1'b0;
		end
		else
		begin
			core_feature_config_ff <= nxt_cfg;
			creg_ack_out           <= creg_ok;                                              // [R9]
			creg_rdata_out         <= (creg_ok && !creg_write_in) ? core_feature_config_ff : '0;
			dbg_ack_out            <= dbg_load || dbg_store;
			dbg_rdata_out          <= dbg_load ? core_feature_config_ff : '0;
			reset_event_out        <= nxt_reset_event;
		end
	end

	// interrupt entry
	irq_st_e    irq_st_ff;
	logic [2:0] mask_ff;
	logic [2:0] taken_level_ff;
	logic       raise_ff;
	logic       lvl7_prev_ff;
	wire        lvl7_now     = irq_req_in && (irq_level_in == `CFG_EDGE_LEVEL);
	wire        lvl7_edge    = lvl7_now && !lvl7_prev_ff;
	wire        irq_above    = irq_req_in && (irq_level_in > mask_ff);
	wire        irq_take     = (irq_st_ff == IRQ_IDLE) && (irq_above || lvl7_edge);     // [R10]
	wire        fetch_done   = (irq_st_ff == IRQ_FETCH) && vector_fetch_ack_in;
	wire        direct_done  = irq_take && !cfg.vector_fetch_cycle_en;                    // [R3]
	wire        entry_done   = direct_done || fetch_done;
	wire        entry_raise  = fetch_done ? raise_ff : cfg.mask_raise_to_top;
	wire [2:0]  entry_level  = fetch_done ? taken_level_ff : irq_level_in;
	wire [2:0]  entry_mask   = entry_raise ? `CFG_MASK_TOP : entry_level;                 // [R4]
	wire [2:0]  nxt_mask     = entry_done ? entry_mask : mask_wr_in ? mask_wdata_in : mask_ff;
	irq_st_e    nxt_irq_st;
	assign nxt_irq_st = (irq_take && cfg.vector_fetch_cycle_en) ? IRQ_FETCH :             // [R3]
		fetch_done ? IRQ_IDLE : irq_st_ff;

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			irq_st_ff              <= IRQ_IDLE;
			mask_ff                <= `CFG_MASK_RESET;
			taken_level_ff         <= '0;
			raise_ff               <= 1'b0;
			lvl7_prev_ff           <= 1'b0;
			vector_fetch_cycle_out <= 1'b0;
			vector_valid_out       <= 1'b0;
			vector_out             <= '0;
		end
		else
		begin
			irq_st_ff              <= nxt_irq_st;
			mask_ff                <= nxt_mask;
			taken_level_ff         <= irq_take ? irq_level_in : taken_level_ff;
			raise_ff               <= irq_take ? cfg.mask_raise_to_top : raise_ff;
			// held while busy so a level-7 edge during a fetch is not lost
			lvl7_prev_ff           <= (irq_st_ff == IRQ_IDLE) ? lvl7_now : lvl7_prev_ff;
			vector_fetch_cycle_out <= nxt_irq_st == IRQ_FETCH;
			vector_valid_out       <= entry_done;
			vector_out             <= fetch_done ? vector_fetch_data_in :
				direct_done ? irq_vector_in : vector_out;
		end
	end
	assign irq_level_mask_out = mask_ff;

	// memory write path
	wr_st_e wr_st_ff;
	logic   buffered_ff;
	wire    wr_take  = wr_req_in && wr_ready_out;
	wire    mem_end  = (wr_st_ff == WR_BUSY) && mem_ack_in;
	wire    nxt_done = (wr_take && !cfg.write_buffer_off) || (mem_end && !buffered_ff);  // [R5]
	wr_st_e nxt_wr_st;
	assign nxt_wr_st = wr_take ? WR_BUSY : mem_end ? WR_IDLE : wr_st_ff;

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			wr_st_ff      <= WR_IDLE;
			buffered_ff   <= 1'b0;
			wr_ready_out  <= 1'b1;
			wr_done_out   <= 1'b0;
			wr_err_out    <= 1'b0;
			mem_wr_out    <= 1'b0;
			mem_addr_out  <= '0;
			mem_wdata_out <= '0;
		end
		else
		begin
			wr_st_ff      <= nxt_wr_st;
			buffered_ff   <= wr_take ? !cfg.write_buffer_off : buffered_ff;
			wr_ready_out  <= nxt_wr_st == WR_IDLE;
			wr_done_out   <= nxt_done;
			wr_err_out    <= mem_end && !buffered_ff && mem_err_in;                         // [R6]
			mem_wr_out    <= nxt_wr_st == WR_BUSY;
			mem_addr_out  <= wr_take ? wr_addr_in : mem_addr_out;
			mem_wdata_out <= wr_take ? wr_data_in : mem_wdata_out;
		end
	end

	// flash read path with one-entry next-address speculation
	fl_st_e            fl_st_ff, nxt_fl_st;
	logic [CNT_W-1:0]  fl_cnt_ff, nxt_fl_cnt;
	logic [ADDR_W-1:0] nxt_fl_addr;
	logic              pend_ff, nxt_pend, buf_ff, nxt_buf, nxt_fl_done;
	logic [31:0]       nxt_fl_data;
	wire               fl_take  = fl_req_in && fl_ready_out;
	wire               cnt_zero = fl_cnt_ff == '0;
	wire               same_adr = fl_addr_in == flash_addr_out;
	wire               spec_go  = !cfg.flash_spec_off;                                     // [R7]

	always_comb
	begin
		nxt_fl_st   = fl_st_ff;
		nxt_fl_cnt  = cnt_zero ? fl_cnt_ff : CNT_W'(fl_cnt_ff - 1'b1);
		nxt_fl_addr = flash_addr_out;
		nxt_pend    = pend_ff;
		nxt_buf     = buf_ff;
		nxt_fl_done = 1'b0;
		nxt_fl_data = fl_rdata_out;
		unique case (fl_st_ff)
			FL_IDLE:
			begin
				if (fl_take && buf_ff && same_adr && spec_go)
				begin
					nxt_fl_done = 1'b1;
					nxt_buf     = 1'b0;
					nxt_fl_st   = FL_SPEC;
					nxt_fl_addr = flash_addr_out + STEP;
					nxt_fl_cnt  = CNT_LOAD;
				end
				else if (fl_take)
				begin
					nxt_buf     = 1'b0;
					nxt_fl_st   = FL_DEMAND;
					nxt_fl_addr = fl_addr_in;
					nxt_fl_cnt  = CNT_LOAD;                                                   // [R8]
				end
			end
			FL_DEMAND:
			begin
				if (cnt_zero)
				begin
					nxt_fl_done = 1'b1;
					nxt_fl_data = flash_rdata_in;
					nxt_fl_st   = spec_go ? FL_SPEC : FL_IDLE;                                 // [R7]
					nxt_fl_addr = flash_addr_out + STEP;
					nxt_fl_cnt  = CNT_LOAD;
				end
			end
			FL_SPEC:
			begin
				if (fl_take && !same_adr)
				begin
					nxt_pend    = 1'b0;
					nxt_fl_st   = FL_DEMAND;
					nxt_fl_addr = fl_addr_in;
					nxt_fl_cnt  = CNT_LOAD;
				end
				else if (cnt_zero)
				begin
					nxt_fl_data = flash_rdata_in;
					nxt_fl_done = pend_ff || fl_take;
					nxt_pend    = 1'b0;
					nxt_buf     = !(pend_ff || fl_take);
					nxt_fl_st   = (pend_ff || fl_take) && spec_go ? FL_SPEC : FL_IDLE;
					nxt_fl_addr = (pend_ff || fl_take) ? flash_addr_out + STEP : flash_addr_out;
					nxt_fl_cnt  = CNT_LOAD;
				end
				else if (fl_take)
				begin
					nxt_pend = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			fl_st_ff       <= FL_IDLE;
			fl_cnt_ff      <= '0;
			pend_ff        <= 1'b0;
			buf_ff         <= 1'b0;
			fl_ready_out   <= 1'b1;
			fl_done_out    <= 1'b0;
			fl_rdata_out   <= '0;
			flash_rd_out   <= 1'b0;
			flash_addr_out <= '0;
		end
		else
		begin
			fl_st_ff       <= nxt_fl_st;
			fl_cnt_ff      <= nxt_fl_cnt;
			pend_ff        <= nxt_pend;
			buf_ff         <= nxt_buf;
			fl_ready_out   <= (nxt_fl_st == FL_IDLE) || (nxt_fl_st == FL_SPEC && !nxt_pend);
			fl_done_out    <= nxt_fl_done;
			fl_rdata_out   <= nxt_fl_data;
			flash_rd_out   <= nxt_fl_st != FL_IDLE;
			flash_addr_out <= nxt_fl_addr;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	addr_reset_a: assert property (|addr_fault_in && !cfg.addr_fault_reset_off |=> reset_event_out) // [R1]
		else $error("address fault did not raise a reset event");
	reset_off_a: assert property (reset_event_out |-> $past(|addr_fault_in || |instr_fault_in || creg_user)) // [R2]
		else $error("reset event without a cause");
	instr_reset_a: assert property (|instr_fault_in && !cfg.instr_fault_reset_off |=> reset_event_out) // [R2]
		else $error("instruction fault did not raise a reset event");
	fetch_cycle_a: assert property (irq_take && cfg.vector_fetch_cycle_en |=> vector_fetch_cycle_out && !vector_valid_out) // [R3]
		else $error("vector fetch cycle not started");
	direct_vec_a: assert property (direct_done |=> vector_valid_out && vector_out == $past(irq_vector_in)) // [R3]
		else $error("signalled vector not used");
	mask_raise_a: assert property (entry_done && entry_raise |=> irq_level_mask_out == `CFG_MASK_TOP) // [R4]
		else $error("mask not raised to top level");
	mask_block_a: assert property (irq_req_in && irq_level_in <= mask_ff && !lvl7_edge |-> !irq_take) // [R10]
		else $error("masked request taken");
	buffered_done_a: assert property (wr_take && !cfg.write_buffer_off |=> wr_done_out ##1 !wr_done_out) // [R5]
		else $error("buffered write not finished at once");
	unbuf_wait_a: assert property (wr_take && cfg.write_buffer_off |=> !wr_done_out throughout (!mem_ack_in [*1])) // [R5]
		else $error("unbuffered write finished early");
	buffered_err_a: assert property (mem_end && buffered_ff |=> !wr_err_out) // [R6]
		else $error("buffered write error reported");
	flash_time_a: assert property (fl_st_ff == FL_IDLE && fl_take && !(buf_ff && same_adr && spec_go) |=> flash_rd_out [*2] ##1 fl_done_out) // [R8]
		else $error("flash read not two cycles");
	spec_off_a: assert property (fl_st_ff == FL_DEMAND && cnt_zero && cfg.flash_spec_off |=> fl_st_ff == FL_IDLE) // [R7]
		else $error("speculation ran while disabled");
	reserved_a: assert property ((core_feature_config_ff & ~`CFG_IMPL_MASK) == '0) // [R12]
		else $error("reserved configuration bit set");
	user_access_a: assert property (creg_user && !dbg_cmd_valid_in |=> !creg_ack_out && $stable(core_feature_config_ff)) // [R9]
		else $error("user mode reached the configuration register");

	buffered_wr_c: cover property (wr_take && !cfg.write_buffer_off ##1 wr_done_out);
	fetch_cycle_c: cover property (vector_fetch_cycle_out ##1 vector_valid_out);
	spec_hit_c: cover property (fl_st_ff == FL_SPEC && fl_take && same_adr ##[1:3] fl_done_out);
	reset_evt_c: cover property (reset_event_out);

endmodule : core_config_register

//--- sim/far_side_model.sv
module far_side_model
	import core_config_pkg::*;
#(
	parameter int         ACK_DELAY = 2,
	parameter logic [7:0] VEC_DATA  = 8'h5C
)(
	input  wire logic        clk_in,
	input  wire logic        mem_fail_in,
	input  wire logic        vector_fetch_cycle_in,
	output logic             vector_fetch_ack_out,
	output logic [7:0]       vector_fetch_data_out,
	input  wire logic        mem_wr_in,
	output logic             mem_ack_out,
	output logic             mem_err_out,
	input  wire logic        flash_rd_in,
	input  wire logic [23:0] flash_addr_in,
	output logic [31:0]      flash_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int vcnt = 0;
	int mcnt = 0;
	initial {vector_fetch_ack_out, vector_fetch_data_out, mem_ack_out, mem_err_out} = '0;
	// data bus shows garbage outside an answer or an array access
	assign flash_rdata_out = flash_rd_in ? {8'hA5, flash_addr_in} : ~{8'hA5, flash_addr_in};
	always @(posedge clk_in)
	begin
		vector_fetch_ack_out <= 1'h0;
		vector_fetch_data_out <= ~VEC_DATA;
		mem_ack_out <= 1'h0;
		mem_err_out <= 1'h0;
		if (vector_fetch_cycle_in && !vector_fetch_ack_out)
		begin
			vcnt <= (vcnt == ACK_DELAY) ? 0 : vcnt + 1;
			if (vcnt == ACK_DELAY)
				{vector_fetch_ack_out, vector_fetch_data_out} <= {1'h1, VEC_DATA};
		end
		if (mem_wr_in && !mem_ack_out)
		begin
			mcnt <= (mcnt == ACK_DELAY) ? 0 : mcnt + 1;
			if (mcnt == ACK_DELAY)
				{mem_ack_out, mem_err_out} <= {1'h1, mem_fail_in};
		end
	end
endmodule : far_side_model

//--- sim/tb_core_config_register.sv
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_core_config_register
	import core_config_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 0, reset_in = 1, supervisor_in = 0, creg_req_in = 0, creg_write_in = 0;
	logic dbg_cmd_valid_in = 0, irq_req_in = 0, mask_wr_in = 0, wr_req_in = 0, fl_req_in = 0;
	logic [11:0] creg_addr_in = '0;
	logic [31:0] creg_wdata_in = '0, dbg_wdata_in = '0, wr_data_in = '0, rd;
	logic [7:0] dbg_cmd_in = '0, irq_vector_in = '0, vector_out, vector_fetch_data_in;
	logic [2:0] irq_level_in = '0, mask_wdata_in = '0, irq_level_mask_out;
	logic [23:0] wr_addr_in = '0, fl_addr_in = '0, mem_addr_out, flash_addr_out;
	addr_fault_s addr_fault_in = '0;
	instr_fault_s instr_fault_in = '0;
	logic creg_ack_out, dbg_ack_out, reset_event_out, vector_fetch_cycle_out, vector_fetch_ack_in;
	logic vector_valid_out, wr_ready_out, wr_done_out, wr_err_out, mem_wr_out, mem_ack_in;
	logic mem_err_in, fl_ready_out, fl_done_out, flash_rd_out, ak, mem_fail = 1;
	logic [31:0] creg_rdata_out, dbg_rdata_out, mem_wdata_out, fl_rdata_out, flash_rdata_in;
	int num_errors = 0, n_compared = 0;

	core_config_register #(.ADDR_W(24), .FLASH_CYC(2)) i_core_config_register (.*);
	far_side_model i_far_side_model (.clk_in(clk_in), .mem_fail_in(mem_fail),
		.vector_fetch_cycle_in(vector_fetch_cycle_out), .vector_fetch_ack_out(vector_fetch_ack_in),
		.vector_fetch_data_out(vector_fetch_data_in), .mem_wr_in(mem_wr_out),
		.mem_ack_out(mem_ack_in), .mem_err_out(mem_err_in), .flash_rd_in(flash_rd_out),
		.flash_addr_in(flash_addr_out), .flash_rdata_out(flash_rdata_in));

	always #10 clk_in = ~clk_in;

	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	task automatic creg(input logic w, s, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		{creg_req_in, creg_write_in, supervisor_in, creg_addr_in, creg_wdata_in} <= {1'h1, w, s, a, d};
		@(posedge clk_in);
		creg_req_in <= 1'h0;
		#1;
		{ak, rd} = {creg_ack_out, creg_rdata_out};
	endtask : creg

	task automatic dbg(input logic [7:0] c, input logic [31:0] d);
		@(posedge clk_in);
		{dbg_cmd_valid_in, dbg_cmd_in, dbg_wdata_in} <= {1'h1, c, d};
		@(posedge clk_in);
		dbg_cmd_valid_in <= 1'h0;
		#1;
		{ak, rd} = {dbg_ack_out, dbg_rdata_out};
	endtask : dbg

	task automatic set_cfg(input logic [31:0] v);
		creg(1'h1, 1'h1, 12'h802, v);
		`CHK("cfg write ack", 1'h1, ak)
	endtask : set_cfg

	task automatic t_regs();
		creg(1'h0, 1'h1, 12'h802, '0);
		`CHK("reset value", 32'h0, rd)
		`CHK("mask reset", 3'h7, irq_level_mask_out)
		creg(1'h1, 1'h1, 12'h802, 32'hFA00_0000);
		creg(1'h0, 1'h1, 12'h802, '0);
		`CHK("sup read", 32'hFA00_0000, rd)
		dbg(8'hC2, 32'h0A00_0000);
		`CHK("store ack", 1'h1, ak)
		creg(1'h1, 1'h0, 12'h802, 32'hFA00_0000);
		`CHK("user ack", 1'h0, ak)
		`CHK("user fault", 1'h1, reset_event_out)
		creg(1'h1, 1'h1, 12'h801, '0);
		`CHK("other addr ack", 1'h0, ak)
		dbg(8'hE1, '0);
		`CHK("other cmd ack", 1'h0, ak)
		dbg(8'hE2, '0);
		`CHK("load", 32'h0A00_0000, rd)
	endtask : t_regs

	task automatic t_faults();
		for (int c = 0; c < 4; c++)
			for (int i = 0; i < 8; i++)
			begin
				set_cfg({c[0], c[1], 30'h0});
				@(posedge clk_in);
				if (i < 4)
					addr_fault_in <= addr_fault_s'(4'h1 << i);
				else
					instr_fault_in <= instr_fault_s'(4'h1 << (i - 4));
				@(posedge clk_in);
				{addr_fault_in, instr_fault_in} <= '0;
				#1;
				`CHK("fault reset", (i < 4) ? !c[0] : !c[1], reset_event_out)
			end
	endtask : t_faults

	task automatic mask_set(input logic [2:0] m);
		@(posedge clk_in);
		{mask_wr_in, mask_wdata_in} <= {1'h1, m};
		@(posedge clk_in);
		mask_wr_in <= 1'h0;
	endtask : mask_set

	task automatic irq(input logic [2:0] l, input logic [7:0] v, input logic tk, input logic [2:0] m);
		@(posedge clk_in);
		{irq_req_in, irq_level_in, irq_vector_in} <= {1'h1, l, v};
		@(posedge clk_in);
		irq_req_in <= 1'h0;
		#1;
		`CHK("irq taken", tk, vector_valid_out)
		`CHK("mask", m, irq_level_mask_out)
		if (tk)
			`CHK("vector", v, vector_out)
	endtask : irq

	task automatic t_irq();
		set_cfg('0);
		mask_set(3'h0);
		irq(3'h3, 8'h40, 1'h1, 3'h3);
		irq(3'h3, 8'h41, 1'h0, 3'h3);
		irq(3'h2, 8'h42, 1'h0, 3'h3);
		set_cfg(32'h1000_0000);
		mask_set(3'h1);
		irq(3'h5, 8'h43, 1'h1, 3'h7);
		irq(3'h6, 8'h44, 1'h0, 3'h7);
		irq(3'h7, 8'h47, 1'h1, 3'h7);
		set_cfg(32'h2000_0000);
		mask_set(3'h0);
		@(posedge clk_in);
		{irq_req_in, irq_level_in, irq_vector_in} <= {1'h1, 3'h4, 8'h40};
		@(posedge clk_in);
		irq_req_in <= 1'h0;
		#1;
		`CHK("fetch cycle", 1'h1, vector_fetch_cycle_out)
		for (int k = 0; k < 20 && vector_valid_out !== 1'h1; k++)
		begin
			@(posedge clk_in);
			#1;
		end
		`CHK("fetched vector", 8'h5C, vector_out)
		`CHK("fetch mask", 3'h4, irq_level_mask_out)
	endtask : t_irq

	task automatic t_write(input logic off);
		logic seen_err;
		logic prev_ack;
		set_cfg(off ? 32'h0800_0000 : '0);
		@(posedge clk_in);
		{wr_req_in, wr_addr_in, wr_data_in} <= {1'h1, 24'h12_3456, 32'hCAFE_0001};
		@(posedge clk_in);
		wr_req_in <= 1'h0;
		#1;
		`CHK("immediate done", !off, wr_done_out)
		`CHK("mem data", 32'hCAFE_0001, mem_wdata_out)
		`CHK("mem addr", 24'h12_3456, mem_addr_out)
		`CHK("mem strobe", 1'h1, mem_wr_out)
		`CHK("ready low", 1'h0, wr_ready_out)
		seen_err = wr_err_out;
		for (int k = 0; k < 20 && wr_ready_out !== 1'h1; k++)
		begin
			prev_ack = mem_ack_in;
			@(posedge clk_in);
			#1;
			seen_err |= wr_err_out;
			if (off && wr_done_out === 1'h1)
				`CHK("done after ack", 1'h1, prev_ack)
		end
		`CHK("error reported", off, seen_err)
	endtask : t_write

	task automatic fl_read(input logic [23:0] a, input logic hit);
		@(posedge clk_in);
		{fl_req_in, fl_addr_in} <= {1'h1, a};
		@(posedge clk_in);
		fl_req_in <= 1'h0;
		#1;
		if (hit)
			`CHK("hit done", 1'h1, fl_done_out)
		else
		begin
			`CHK("array addr", a, flash_addr_out)
			`CHK("busy not ready", 1'h0, fl_ready_out)
			@(posedge clk_in);
			#1;
			`CHK("second cycle", 1'h1, flash_rd_out)
			@(posedge clk_in);
			#1;
			`CHK("miss done", 1'h1, fl_done_out)
		end
		`CHK("flash data", {8'hA5, a}, fl_rdata_out)
	endtask : fl_read

	task automatic t_flash(input logic off);
		set_cfg(off ? 32'h0200_0000 : '0);
		fl_read(24'h00_0100, 1'h0);
		repeat (4) @(posedge clk_in);
		fl_read(24'h00_0104, !off);
	endtask : t_flash

	initial
	begin
		#200000;
		num_errors++;
		conclude();
	end

	initial
	begin
		repeat (3) @(posedge clk_in);
		reset_in <= 1'h0;
		t_regs();
		t_faults();
		t_irq();
		t_write(1'h0);
		t_write(1'h1);
		t_flash(1'h1);
		t_flash(1'h0);
		conclude();
	end
endmodule : tb_core_config_register
